// *** src/fivec_pkg.sv ***
// Purpose: Shared constants and types for the fast vector and enable register block.
// Assumes: APB with 32-bit data and a 12-bit byte address.
// Notes:   Every register takes one aligned word at its byte address.
package fivec_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IRQ_N      = 39;
  localparam int unsigned IRQ_HI_BASE = 32;
  localparam int unsigned IRQ_HI_W   = 7;
  localparam int unsigned NUM_W      = 8;
  localparam int unsigned NUMS_W     = 16;
  localparam int unsigned CH0_NUM_LSB = 0;
  localparam int unsigned CH1_NUM_LSB = 8;
  localparam int unsigned ON_BIT     = 0;
  localparam int unsigned CHAN_N     = 2;

  localparam logic [ADDR_W-1:0] OFF_IRQ_NUMS = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_CH0_ADDR = 12'h060;
  localparam logic [ADDR_W-1:0] OFF_CH1_ADDR = 12'h064;
  localparam logic [ADDR_W-1:0] OFF_SET_LO   = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_SET_HI   = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_CLR_LO   = 12'h180;
  localparam logic [ADDR_W-1:0] OFF_CLR_HI   = 12'h184;

  localparam logic [NUMS_W-1:0] RST_IRQ_NUMS = 16'h0000;
  localparam logic [31:1]       RST_ADDR     = 31'h0000_0000;
  localparam logic              RST_ON       = 1'b0;
  localparam logic [IRQ_N-1:0]  RST_ENA      = 39'h00_0000_0000;

  // Interrupts 12, 14 and 16 to 38 exist; every other enable bit is reserved.
  localparam logic [IRQ_N-1:0]  ENA_IMPL     = 39'h7F_FFFF_5000;

  localparam int unsigned SEL_NUMS   = 0;
  localparam int unsigned SEL_FAST_CHANNEL0_HANDLER_ADDR  = 1;
  localparam int unsigned SEL_FAST_CHANNEL1_HANDLER_ADDR  = 2;
  localparam int unsigned SEL_SET_LO = 3;
  localparam int unsigned SEL_SET_HI = 4;
  localparam int unsigned SEL_CLR_LO = 5;
  localparam int unsigned SEL_CLR_HI = 6;
  localparam int unsigned SEL_N      = 7;

  typedef logic [SEL_N-1:0] fivec_sel_type;

  typedef enum logic [1:0]
  {
    APB_IDLE   = 2'h1,
    APB_ACCESS = 2'h2
  } fivec_apb_state_type;

  function automatic fivec_sel_type reg_sel(input logic [ADDR_W-1:0] addr);
    fivec_sel_type s;
    s = '0;
    s[SEL_NUMS]   = (addr == OFF_IRQ_NUMS);
    s[SEL_FAST_CHANNEL0_HANDLER_ADDR]  = (addr == OFF_CH0_ADDR);
    s[SEL_FAST_CHANNEL1_HANDLER_ADDR]  = (addr == OFF_CH1_ADDR);
    s[SEL_SET_LO] = (addr == OFF_SET_LO);
    s[SEL_SET_HI] = (addr == OFF_SET_HI);
    s[SEL_CLR_LO] = (addr == OFF_CLR_LO);
    s[SEL_CLR_HI] = (addr == OFF_CLR_HI);
    return s;
  endfunction : reg_sel

endpackage : fivec_pkg

// *** src/fivec_apb_phase.sv ***
// Purpose: APB phase tracker that gives one access cycle with no wait states.
// Assumes: Master keeps to APB setup and access phases.
// Notes:   pready comes straight from the phase register.
`timescale 1ns/1ps
module fivec_apb_phase
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic [fivec_pkg::ADDR_W-1:0] paddr,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            setup_stb,
  output logic                            access_stb
);

  fivec_pkg::fivec_apb_state_type state_r;
  fivec_pkg::fivec_apb_state_type state_nxt;

  always_comb
  begin
    case (state_r)
      fivec_pkg::APB_IDLE:   state_nxt = setup_stb ? fivec_pkg::APB_ACCESS : fivec_pkg::APB_IDLE;
      fivec_pkg::APB_ACCESS: state_nxt = setup_stb ? fivec_pkg::APB_ACCESS : fivec_pkg::APB_IDLE;
      default:               state_nxt = fivec_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= fivec_pkg::APB_IDLE;
    else
      state_r <= state_nxt;
  end

  assign setup_stb  = psel & ~penable;
  assign pready     = (state_r == fivec_pkg::APB_ACCESS);
  assign access_stb = pready & psel & penable;
  // An unmapped or misaligned address is answered with an error and no effect.
  assign pslverr    = access_stb & ~(|fivec_pkg::reg_sel(paddr));

endmodule : fivec_apb_phase

// *** src/fivec_fast_match.sv ***
// Purpose: Compares a taken interrupt number with both fast channels.
// Assumes: take_num is stable in the cycle that take_valid is high.
// Notes:   Channel 0 wins when both channels name the same interrupt.
`timescale 1ns/1ps
module fivec_fast_match
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      take_valid,
  input  wire logic [fivec_pkg::NUM_W-1:0] take_num,
  input  wire logic [fivec_pkg::CHAN_N-1:0] chan_on,
  input  wire logic [fivec_pkg::NUMS_W-1:0] chan_nums,
  input  wire logic [31:1]               ch0_addr,
  input  wire logic [31:1]               ch1_addr,
  output logic                           fast_valid,
  output logic                           fast_hit,
  output logic                           fast_chan,
  output logic [31:0]                    fast_handler_addr
);

  logic [fivec_pkg::CHAN_N-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < fivec_pkg::CHAN_N; g++)
    begin : g_chan
      assign hit[g] = chan_on[g] & (take_num == chan_nums[g*fivec_pkg::NUM_W +: fivec_pkg::NUM_W]);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_valid        <= 1'b0;
      fast_hit          <= 1'b0;
      fast_chan         <= 1'b0;
      fast_handler_addr <= 32'h0000_0000;
    end
    else
    begin
      fast_valid <= take_valid;
      fast_hit   <= take_valid & (|hit);
      fast_chan  <= take_valid & ~hit[0] & hit[1];
      if (take_valid & hit[0])
        fast_handler_addr <= {ch0_addr, 1'b0};
      else if (take_valid & hit[1])
        fast_handler_addr <= {ch1_addr, 1'b0};
      else
        fast_handler_addr <= 32'h0000_0000;
    end
  end

endmodule : fivec_fast_match

// *** src/fivec_top.sv ***
// Purpose: Fast vector channels and per-interrupt enables behind an APB slave.
// Assumes: One clock, inputs synchronous to it, zero-wait APB master.
// Notes:   Enable set and clear registers read back the current enables.
`timescale 1ns/1ps
module fivec_top
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fivec_pkg::ADDR_W-1:0] paddr,
  input  wire logic [fivec_pkg::DATA_W-1:0] pwdata,
  output logic      [fivec_pkg::DATA_W-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [fivec_pkg::IRQ_N-1:0]  irq_enable,
  input  wire logic                         take_valid,
  input  wire logic [fivec_pkg::NUM_W-1:0]  take_num,
  output logic                              fast_valid,
  output logic                              fast_hit,
  output logic                              fast_chan,
  output logic      [31:0]                  fast_handler_addr
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase and decode.

  logic                          setup_stb;
  logic                          access_stb;
  fivec_pkg::fivec_sel_type      sel;
  fivec_pkg::fivec_sel_type      wr_stb;
  logic [fivec_pkg::NUMS_W-1:0]  irq_nums_r;
  logic [31:1]                   ch0_addr_r;
  logic [31:1]                   ch1_addr_r;
  logic                          ch0_on_r;
  logic                          ch1_on_r;
  logic [fivec_pkg::IRQ_N-1:0]   ena_r;
  logic [fivec_pkg::IRQ_N-1:0]   ena_set;
  logic [fivec_pkg::IRQ_N-1:0]   ena_clr;
  logic [fivec_pkg::DATA_W-1:0]  rd_val;
  logic [fivec_pkg::DATA_W-1:0]  prdata_r;

  fivec_apb_phase u_phase
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .paddr      (paddr),
    .pready     (pready),
    .pslverr    (pslverr),
    .setup_stb  (setup_stb),
    .access_stb (access_stb)
  );

  assign sel    = fivec_pkg::reg_sel(paddr);
  // Writes land only at the access edge, so a held request acts exactly once.
  assign wr_stb = (access_stb & pwrite) ? sel : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Fast channel configuration.

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_nums_r <= fivec_pkg::RST_IRQ_NUMS;
    else if (wr_stb[fivec_pkg::SEL_NUMS])
      irq_nums_r <= pwdata[fivec_pkg::NUMS_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0_addr_r <= fivec_pkg::RST_ADDR;
      ch0_on_r   <= fivec_pkg::RST_ON;
    end
    else if (wr_stb[fivec_pkg::SEL_FAST_CHANNEL0_HANDLER_ADDR])
    begin
      ch0_addr_r <= pwdata[31:1];
      ch0_on_r   <= pwdata[fivec_pkg::ON_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch1_addr_r <= fivec_pkg::RST_ADDR;
      ch1_on_r   <= fivec_pkg::RST_ON;
    end
    else if (wr_stb[fivec_pkg::SEL_FAST_CHANNEL1_HANDLER_ADDR])
    begin
      ch1_addr_r <= pwdata[31:1];
      ch1_on_r   <= pwdata[fivec_pkg::ON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enables.  Set and clear live in different words, so they never meet.

  always_comb
  begin
    ena_set = '0;
    ena_clr = '0;
    if (wr_stb[fivec_pkg::SEL_SET_LO])
      ena_set[fivec_pkg::IRQ_HI_BASE-1:0] = pwdata;
    if (wr_stb[fivec_pkg::SEL_SET_HI])
      ena_set[fivec_pkg::IRQ_N-1:fivec_pkg::IRQ_HI_BASE] = pwdata[fivec_pkg::IRQ_HI_W-1:0];
    if (wr_stb[fivec_pkg::SEL_CLR_LO])
      ena_clr[fivec_pkg::IRQ_HI_BASE-1:0] = pwdata;
    if (wr_stb[fivec_pkg::SEL_CLR_HI])
      ena_clr[fivec_pkg::IRQ_N-1:fivec_pkg::IRQ_HI_BASE] = pwdata[fivec_pkg::IRQ_HI_W-1:0];
  end

  genvar g;
  generate
    for (g = 0; g < fivec_pkg::IRQ_N; g++)
    begin : g_ena
      if (fivec_pkg::ENA_IMPL[g])
      begin : g_impl
        always_ff @(posedge clk or negedge rst_n)
        begin
          if (!rst_n)
            ena_r[g] <= fivec_pkg::RST_ENA[g];
          else if (ena_set[g])
            ena_r[g] <= 1'b1;
          else if (ena_clr[g])
            ena_r[g] <= 1'b0;
        end
      end
      else
      begin : g_rsvd
        // Reserved numbers have no flop; writing one there does nothing.
        assign ena_r[g] = 1'b0;
      end
    end
  endgenerate

  assign irq_enable = ena_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle so prdata comes from a flop.

  always_comb
  begin
    rd_val = '0;
    case (1'b1)
      sel[fivec_pkg::SEL_NUMS]:   rd_val[fivec_pkg::NUMS_W-1:0] = irq_nums_r;
      sel[fivec_pkg::SEL_FAST_CHANNEL0_HANDLER_ADDR]:  rd_val = {ch0_addr_r, ch0_on_r};
      sel[fivec_pkg::SEL_FAST_CHANNEL1_HANDLER_ADDR]:  rd_val = {ch1_addr_r, ch1_on_r};
      sel[fivec_pkg::SEL_SET_LO],
      sel[fivec_pkg::SEL_CLR_LO]: rd_val = ena_r[fivec_pkg::IRQ_HI_BASE-1:0];
      sel[fivec_pkg::SEL_SET_HI],
      sel[fivec_pkg::SEL_CLR_HI]:
        rd_val[fivec_pkg::IRQ_HI_W-1:0] = ena_r[fivec_pkg::IRQ_N-1:fivec_pkg::IRQ_HI_BASE];
      default:                    rd_val = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_r <= 32'h0000_0000;
    else if (setup_stb)
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
  end

  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Fast vector lookup toward the core.

  fivec_fast_match u_match
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .take_valid        (take_valid),
    .take_num          (take_num),
    .chan_on           ({ch1_on_r, ch0_on_r}),
    .chan_nums         (irq_nums_r),
    .ch0_addr          (ch0_addr_r),
    .ch1_addr          (ch1_addr_r),
    .fast_valid        (fast_valid),
    .fast_hit          (fast_hit),
    .fast_chan         (fast_chan),
    .fast_handler_addr (fast_handler_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_num0_write;
    wr_stb[fivec_pkg::SEL_NUMS] |=> irq_nums_r[7:0] == $past(pwdata[7:0]);
  endproperty
  a_num0_write: assert property (p_num0_write) else $error("ch0 number not stored");

  property p_num1_write;
    wr_stb[fivec_pkg::SEL_NUMS] |=> irq_nums_r[15:8] == $past(pwdata[15:8])
      && prdata_r[31:16] == 16'h0000;
  endproperty
  a_num1_write: assert property (p_num1_write) else $error("ch1 number not stored");

  property p_fast_channel0_handler_addr_write;
    wr_stb[fivec_pkg::SEL_FAST_CHANNEL0_HANDLER_ADDR] |=> {ch0_addr_r, 1'b0} == {$past(pwdata[31:1]), 1'b0};
  endproperty
  a_fast_channel0_handler_addr_write: assert property (p_fast_channel0_handler_addr_write) else $error("ch0 address not stored");

  property p_on0_write;
    wr_stb[fivec_pkg::SEL_FAST_CHANNEL0_HANDLER_ADDR] |=> ch0_on_r == $past(pwdata[0]);
  endproperty
  a_on0_write: assert property (p_on0_write) else $error("ch0 enable not stored");

  property p_fast_channel1_handler_addr_write;
    wr_stb[fivec_pkg::SEL_FAST_CHANNEL1_HANDLER_ADDR] |=> ch1_addr_r == $past(pwdata[31:1]);
  endproperty
  a_fast_channel1_handler_addr_write: assert property (p_fast_channel1_handler_addr_write) else $error("ch1 address not stored");

  property p_on1_write;
    wr_stb[fivec_pkg::SEL_FAST_CHANNEL1_HANDLER_ADDR] |=> ch1_on_r == $past(pwdata[0]);
  endproperty
  a_on1_write: assert property (p_on1_write) else $error("ch1 enable not stored");

  property p_set_lo;
    wr_stb[fivec_pkg::SEL_SET_LO] |=>
      ((irq_enable[31:16] & $past(pwdata[31:16])) == $past(pwdata[31:16]))
      && ((irq_enable[31:16] & ~$past(pwdata[31:16]))
          == ($past(irq_enable[31:16]) & ~$past(pwdata[31:16])));
  endproperty
  a_set_lo: assert property (p_set_lo) else $error("set of 16-31 wrong");

  property p_set_12_14;
    wr_stb[fivec_pkg::SEL_SET_LO] && pwdata[12] && pwdata[14] |=> irq_enable[12] && irq_enable[14];
  endproperty
  a_set_12_14: assert property (p_set_12_14) else $error("set of 12 or 14 wrong");

  property p_rsvd_zero;
    irq_enable[11:0] == 12'h000 && !irq_enable[13] && !irq_enable[15];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved enable set");

  property p_set_hi;
    wr_stb[fivec_pkg::SEL_SET_HI] |=>
      (irq_enable[38:32] == ($past(irq_enable[38:32]) | $past(pwdata[6:0])));
  endproperty
  a_set_hi: assert property (p_set_hi) else $error("set of 32-38 wrong");

  property p_clr_lo;
    wr_stb[fivec_pkg::SEL_CLR_LO] |=>
      (irq_enable[31:16] == ($past(irq_enable[31:16]) & ~$past(pwdata[31:16])));
  endproperty
  a_clr_lo: assert property (p_clr_lo) else $error("clear of 16-31 wrong");

  property p_clr_12_14;
    wr_stb[fivec_pkg::SEL_CLR_LO] |=>
      irq_enable[12] == ($past(irq_enable[12]) & ~$past(pwdata[12]))
      && irq_enable[14] == ($past(irq_enable[14]) & ~$past(pwdata[14]));
  endproperty
  a_clr_12_14: assert property (p_clr_12_14) else $error("clear of 12 or 14 wrong");

  property p_clr_hi;
    wr_stb[fivec_pkg::SEL_CLR_HI] |=>
      (irq_enable[38:32] == ($past(irq_enable[38:32]) & ~$past(pwdata[6:0])));
  endproperty
  a_clr_hi: assert property (p_clr_hi) else $error("clear of 32-38 wrong");

  property p_fast0_hit;
    take_valid && ch0_on_r && take_num == irq_nums_r[7:0] |=>
      fast_hit && !fast_chan && fast_handler_addr == {$past(ch0_addr_r), 1'b0};
  endproperty
  a_fast0_hit: assert property (p_fast0_hit) else $error("ch0 vector not presented");

  property p_fast_off;
    take_valid && !ch0_on_r && !ch1_on_r |=> fast_valid && !fast_hit;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("hit from a disabled channel");

  property p_read_back;
    setup_stb && !pwrite && sel[fivec_pkg::SEL_FAST_CHANNEL1_HANDLER_ADDR] ##1 access_stb |->
      prdata == {ch1_addr_r, ch1_on_r};
  endproperty
  a_read_back: assert property (p_read_back) else $error("ch1 read data wrong");

  property p_unmapped;
    access_stb && !(|sel) |-> pslverr ##1 $stable(ena_r);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_fast1_hit;
    take_valid && ch1_on_r && take_num == irq_nums_r[15:8]
      && !(ch0_on_r && take_num == irq_nums_r[7:0]) |=>
      fast_hit && fast_chan && fast_handler_addr == {$past(ch1_addr_r), 1'b0};
  endproperty
  a_fast1_hit: assert property (p_fast1_hit) else $error("ch1 vector not presented");

  property p_fast_idle;
    !take_valid |=> !fast_valid && !fast_hit && fast_handler_addr == 32'h0000_0000;
  endproperty
  a_fast_idle: assert property (p_fast_idle) else $error("lookup output without a take");

  property p_set_each;
    wr_stb[fivec_pkg::SEL_SET_LO] |=>
      (irq_enable[12] || !$past(pwdata[12])) && (irq_enable[14] || !$past(pwdata[14]));
  endproperty
  a_set_each: assert property (p_set_each) else $error("single set of 12 or 14 lost");

  // A well-behaved master gets exactly one access cycle per setup cycle.
  property p_ready_once;
    setup_stb |=> pready ##1 !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("access not exactly one cycle");

  property p_write_rdata;
    setup_stb && pwrite |=> prdata == 32'h0000_0000;
  endproperty
  a_write_rdata: assert property (p_write_rdata) else $error("write returned read data");

  c_set_then_clr: cover property (wr_stb[fivec_pkg::SEL_SET_HI] ##[1:20]
    wr_stb[fivec_pkg::SEL_CLR_HI]);
  c_fast_hit1: cover property (take_valid ##1 fast_hit && fast_chan);
  c_err: cover property (pslverr);
  c_read_ena: cover property (access_stb && !pwrite && sel[fivec_pkg::SEL_SET_LO]);

endmodule : fivec_top

// *** tb/fivec_core_model.sv ***
// Purpose: Behavioural stand-in for the core that takes interrupts and names each one by number.
// Assumes: The bench asks for at most one take per cycle through go and go_num.
// Notes:   The number is scrambled while idle, so a held value never looks like a take.
`timescale 1ns/1ps
module fivec_core_model
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         go,
  input  wire logic [fivec_pkg::NUM_W-1:0]  go_num,
  output logic                              take_valid,
  output logic      [fivec_pkg::NUM_W-1:0]  take_num
);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      take_valid <= 1'b0;
      take_num   <= 8'h00;
    end
    else
    begin
      take_valid <= go;
      // Idle cycles invert the last number, so the block cannot lean on a stale one.
      take_num   <= go ? go_num : ~take_num;
    end
  end
endmodule : fivec_core_model

// *** tb/fast_irq_vector_and_enable_regs_test.sv ***
// Purpose: Self-checking bench for the fast vector and enable register block.
// Assumes: The APB slave answers by pready; the core model adds one cycle to each take.
// Notes:   Expected reads and lookups are queued; one monitor pops and compares them.
`timescale 1ns/1ps
module fast_irq_vector_and_enable_regs_test;
  logic                             clk = 1'b0;
  logic                             rst_n = 1'b0;
  logic                             psel = 1'b0;
  logic                             penable = 1'b0;
  logic                             pwrite = 1'b0;
  logic [11:0]                      paddr = 12'h000;
  logic [31:0]                      pwdata = 32'h0000_0000;
  logic [31:0]                      prdata;
  logic                             pready;
  logic                             pslverr;
  logic [fivec_pkg::IRQ_N-1:0]      irq_enable;
  logic                             take_valid;
  logic [7:0]                       take_num;
  logic                             go = 1'b0;
  logic [7:0]                       go_num = 8'h00;
  logic                             fast_valid;
  logic                             fast_hit;
  logic                             fast_chan;
  logic [31:0]                      fast_handler_addr;
  logic [7:0]                       n0, n1;
  logic                             on0, on1;
  logic [31:1]                      a0, a1;
  logic [fivec_pkg::IRQ_N-1:0]      ena;
  logic [32:0]                      rd_q[$];
  logic [33:0]                      fq[$];
  logic [32:0]                      mon_e;
  int                               error_cnt = 0;
  int                               n_compared = 0;
  int                               seed = 79;
  localparam logic [11:0] OFFS [7] = '{fivec_pkg::OFF_IRQ_NUMS, fivec_pkg::OFF_CH0_ADDR,
    fivec_pkg::OFF_CH1_ADDR, fivec_pkg::OFF_SET_LO, fivec_pkg::OFF_SET_HI,
    fivec_pkg::OFF_CLR_LO, fivec_pkg::OFF_CLR_HI};

  always #5 clk = ~clk;

  fivec_top u_fivec_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_enable(irq_enable), .take_valid(take_valid),
    .take_num(take_num), .fast_valid(fast_valid), .fast_hit(fast_hit),
    .fast_chan(fast_chan), .fast_handler_addr(fast_handler_addr));

  fivec_core_model u_fivec_core_model (.clk(clk), .rst_n(rst_n), .go(go), .go_num(go_num),
    .take_valid(take_valid), .take_num(take_num));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [38:0] seen, input logic [38:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  function automatic logic [31:0] rexp(input logic [11:0] a);
    case (a)
      fivec_pkg::OFF_IRQ_NUMS: return {16'h0000, n1, n0};
      fivec_pkg::OFF_CH0_ADDR: return {a0, on0};
      fivec_pkg::OFF_CH1_ADDR: return {a1, on1};
      fivec_pkg::OFF_SET_LO, fivec_pkg::OFF_CLR_LO: return ena[31:0];
      default: return {25'h000_0000, ena[38:32]};
    endcase
  endfunction : rexp

  // Channel 0 is checked first: equal numbers on both channels go to channel 0.
  function automatic logic [33:0] fexp(input logic [7:0] n);
    if (on0 && n == n0) return {2'b10, a0, 1'b0};
    if (on1 && n == n1) return {2'b11, a1, 1'b0};
    return 34'h0_0000_0000;
  endfunction : fexp

  // The request holds still until pready is sampled high or 20 cycles pass, then is released.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    rd_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 39'(pready), 39'h00_0000_0001);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
    case (a)
      fivec_pkg::OFF_IRQ_NUMS: {n1, n0} = d[15:0];
      fivec_pkg::OFF_CH0_ADDR: {a0, on0} = d;
      fivec_pkg::OFF_CH1_ADDR: {a1, on1} = d;
      fivec_pkg::OFF_SET_LO: ena[31:0] = ena[31:0] | (d & fivec_pkg::ENA_IMPL[31:0]);
      fivec_pkg::OFF_SET_HI: ena[38:32] = ena[38:32] | d[6:0];
      fivec_pkg::OFF_CLR_LO: ena[31:0] = ena[31:0] & ~(d & fivec_pkg::ENA_IMPL[31:0]);
      fivec_pkg::OFF_CLR_HI: ena[38:32] = ena[38:32] & ~d[6:0];
      default: ;
    endcase
  endtask : wreg

  task automatic rd_all;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, OFFS[i], 32'h0000_0000, {1'b0, rexp(OFFS[i])});
      chk("irq_enable", irq_enable, ena);
    end
  endtask : rd_all

  task automatic take(input logic [7:0] n);
    @(posedge clk);
    go     <= 1'b1;
    go_num <= n;
    fq.push_back(fexp(n));
  endtask : take

  task automatic idle;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      mon_e = rd_q.pop_front();
      if (pwrite) chk("pslverr", 39'(pslverr), 39'(mon_e[32]));
      else chk("prdata", 39'({pslverr, prdata}), 39'(mon_e));
    end
    if (fast_valid === 1'b1)
    begin
      // A lookup that no take asked for must not slip through as a miss.
      chk("fast queue", 39'(fq.size() != 0), 39'h00_0000_0001);
      chk("fast lookup", 39'({fast_hit, fast_chan, fast_handler_addr}),
          39'(fq.size() != 0 ? fq.pop_front() : 34'h3_FFFF_FFFF));
    end
  end

  initial
  begin
    #400_000;
    error_cnt++;
    $display("BAD watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial
  begin
    {n0, n1, on0, on1, a0, a1, ena} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_all();
    // Unmapped and misaligned places are refused and leave every register alone.
    apb(1'b0, 12'h054, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b0, 12'h102, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, 12'h200, 32'hFFFF_FFFF, 33'h1_0000_0000);
    rd_all();
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 7; i++) wreg(OFFS[i], 32'($random(seed)));
      rd_all();
    end
    wreg(fivec_pkg::OFF_SET_LO, 32'hFFFF_FFFF);
    wreg(fivec_pkg::OFF_SET_HI, 32'hFFFF_FFFF);
    rd_all();
    wreg(fivec_pkg::OFF_CLR_LO, 32'hFFFF_FFFF);
    wreg(fivec_pkg::OFF_CLR_HI, 32'hFFFF_FFFF);
    rd_all();
    wreg(fivec_pkg::OFF_IRQ_NUMS, 32'h0000_1C0C);
    wreg(fivec_pkg::OFF_CH0_ADDR, 32'($random(seed)) | 32'h0000_0001);
    wreg(fivec_pkg::OFF_CH1_ADDR, 32'($random(seed)) | 32'h0000_0001);
    for (int k = 0; k < 24; k++)
      take(k % 3 == 0 ? n0 : (k % 3 == 1 ? n1 : 8'($random(seed))));
    idle();
    wreg(fivec_pkg::OFF_CH0_ADDR, {a0, 1'b0});
    take(n0);
    take(n1);
    idle();
    wreg(fivec_pkg::OFF_CH1_ADDR, {a1, 1'b0});
    take(n1);
    idle();
    wreg(fivec_pkg::OFF_IRQ_NUMS, 32'h0000_2626);
    wreg(fivec_pkg::OFF_CH0_ADDR, {a0, 1'b1});
    wreg(fivec_pkg::OFF_CH1_ADDR, {a1, 1'b1});
    take(8'h26);
    take(8'h27);
    idle();
    wreg(fivec_pkg::OFF_SET_HI, 32'h0000_0055);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    {n0, n1, on0, on1, a0, a1, ena} = '0;
    rd_all();
    chk("takes left", 39'(fq.size()), 39'h00_0000_0000);
    tally_and_finish();
  end
endmodule : fast_irq_vector_and_enable_regs_test
